// [logic/wrem_top.v]
// Wiper register and non-volatile memory map, with a two-wire bus slave.
// Assumes scl and sda inputs already synchronous and filtered to clk.
// Summary of operation
// - Seven-bit volatile tap register, 128 positions.
// - Code 00 low end, 7F high end.
// - Rising code moves wiper monotonically upward.
// - Power-up forces tap register to 40 hex.
// - Then stored initial value copied into tap.
// - 2048 bytes as 128 pages of 16.
// - Eleven-bit byte address space decoded.
// - Addresses up to 7FB are general storage.
// - Byte 7FF holds stored initial wiper value.
// - Bit 7 of 7FE is volatile-only select.
// - Select bit volatile, cleared at power-up.
// - Read 7FF gives live or stored value.
// - Write 7FF: tap only, or both.
// - 7FE and 7FF written separately or together.
// - Stop after a write to stored bytes starts self-timed commit.
// - Commit lasts six milliseconds typical.
// - Id byte is 1010, A10..A8, read flag.
// - Bus ignored, data released during commit.
`timescale 1ns/1ps
`default_nettype none
`include "wrem_consts.vh"
module wrem_top #(
	parameter TWC_CYC = `WREM_TWC_CYC,
	parameter BOOT_CYC = `WREM_BOOT_CYC
) (
	input wire clk,
	input wire reset,
	input wire scl,
	input wire sda_in,
	output reg sda_out_r,
	output reg sda_oe_r,
	input wire write_protect_n,
	output reg [6:0] tap_position_r,
	output reg volatile_select_bit_r,
	output reg nv_busy_r
);
	localparam S_IDLE = 3'h0;
	localparam S_ID = 3'h1;
	localparam S_ADDR = 3'h2;
	localparam S_WDATA = 3'h3;
	localparam S_RDATA = 3'h4;
	localparam S_WAIT = 3'h6;
	localparam S_BOOT = 3'h7;
	// Bit counter: 0 to 7 data bits, 8 byte done, 9 the ack clock.
	// The ack clock is counted apart so its rise is never taken as data.
	localparam B_DONE = 4'h8;
	localparam B_ACK = 4'h9;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg scl_d_r;
	reg sda_d_r;
	reg [7:0] shift_r;
	reg [3:0] bit_r;
	reg ack_r;
	reg wrote_nv_r;
	reg [10:0] addr_r;
	reg [3:0] boot_r;
	wire busy;
	wire [7:0] nv_rd;
	reg nv_we;
	reg commit;

	wire scl_rise = scl & ~scl_d_r;
	wire scl_fall = ~scl & scl_d_r;
	wire start_c = scl & scl_d_r & sda_d_r & ~sda_in;
	wire stop_c = scl & scl_d_r & ~sda_d_r & sda_in;

	// Maps an address to the byte the host sees on a read.
	function [7:0] wrem_read_byte;
		input [10:0] a;
		input sel;
		input [6:0] tap;
		input [7:0] nv;
		begin
			if (a == `WREM_ADDR_WIPER)
				wrem_read_byte = sel ? {1'b0, tap} : {1'b0, nv[6:0]};
			else if (a == `WREM_ADDR_ACCESS)
				wrem_read_byte = {sel, 7'h00};
			else
				wrem_read_byte = nv;
		end
	endfunction

	wire [7:0] rd_byte = wrem_read_byte(addr_r, volatile_select_bit_r,
		tap_position_r, nv_rd);

	wrem_nv_array #(
		.TWC_CYC(TWC_CYC)
	) u_nv (
		.clk(clk),
		.reset(reset),
		.rd_addr(addr_r),
		.rd_data(nv_rd),
		.buf_we(nv_we),
		.buf_addr(addr_r),
		.buf_data(shift_r),
		.commit(commit),
		.busy_r(busy)
	);

	always @* begin
		nv_we = 1'b0;
		commit = 1'b0;
		if (state_r == S_WDATA && scl_fall && bit_r == 4'h8 && write_protect_n)
			nv_we = (addr_r == `WREM_ADDR_WIPER) ? ~volatile_select_bit_r :
				(addr_r <= `WREM_ADDR_GP_TOP);
		if (stop_c && wrote_nv_r)
			commit = 1'b1;
	end

	always @* begin
		state_nxt = state_r;
		if (state_r == S_BOOT) begin
			if (boot_r == 4'h0)
				state_nxt = S_IDLE;
		end else if (busy) begin
			state_nxt = S_IDLE;
		end else if (start_c) begin
			state_nxt = S_ID;
		end else if (stop_c) begin
			state_nxt = S_IDLE;
		end else if (scl_fall && bit_r == B_DONE) begin
			case (state_r)
			S_ID: state_nxt = (shift_r[7:4] == `WREM_ID_PATTERN) ?
				(shift_r[0] ? S_RDATA : S_ADDR) : S_WAIT;
			S_ADDR: state_nxt = S_WDATA;
			S_WDATA: state_nxt = write_protect_n ? S_WDATA : S_WAIT;
			default: state_nxt = state_r;
			endcase
		end else if (scl_fall && bit_r == B_ACK) begin
			// A master that does not acknowledge ends the read.
			if (state_r == S_RDATA && !ack_r)
				state_nxt = S_WAIT;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			state_r <= S_BOOT;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			shift_r <= 8'h00;
			bit_r <= 4'h0;
			ack_r <= 1'b0;
			wrote_nv_r <= 1'b0;
			addr_r <= `WREM_ADDR_WIPER;
			boot_r <= BOOT_CYC[3:0];
			tap_position_r <= `WREM_TAP_MID;
			volatile_select_bit_r <= 1'b0;
			sda_out_r <= 1'b0;
			sda_oe_r <= 1'b0;
			nv_busy_r <= 1'b0;
		end else begin
			scl_d_r <= scl;
			sda_d_r <= sda_in;
			state_r <= state_nxt;
			nv_busy_r <= busy;
			if (state_r == S_BOOT) begin
				boot_r <= boot_r - 4'h1;
				// Tap code drives the wiper directly, so order is monotonic.
				if (boot_r == 4'h0)
					tap_position_r <= nv_rd[6:0];
			end else if (busy) begin
				sda_oe_r <= 1'b0;
				bit_r <= 4'h0;
				wrote_nv_r <= 1'b0;
			end else if (start_c) begin
				bit_r <= 4'h0;
				sda_oe_r <= 1'b0;
			end else if (stop_c) begin
				sda_oe_r <= 1'b0;
				wrote_nv_r <= 1'b0;
			end else begin
				if (scl_rise && bit_r < B_DONE) begin
					bit_r <= bit_r + 4'h1;
					// Read bytes go out of shift_r, so it takes no bus bits then.
					if (state_r != S_RDATA)
						shift_r <= {shift_r[6:0], sda_in};
				end
				if (scl_rise && bit_r == B_ACK && state_r == S_RDATA)
					ack_r <= ~sda_in;
				if (scl_fall && bit_r == B_DONE) begin
					bit_r <= B_ACK;
					sda_out_r <= 1'b0;
					sda_oe_r <= 1'b0;
					case (state_r)
					S_ID: begin
						if (shift_r[7:4] == `WREM_ID_PATTERN) begin
							sda_oe_r <= 1'b1;
							if (!shift_r[0])
								addr_r[10:8] <= shift_r[3:1];
						end
					end
					S_ADDR: begin
						addr_r[7:0] <= shift_r;
						sda_oe_r <= 1'b1;
					end
					S_WDATA: begin
						if (write_protect_n) begin
							sda_oe_r <= 1'b1;
							if (addr_r == `WREM_ADDR_ACCESS)
								volatile_select_bit_r <= shift_r[`WREM_SEL_BIT];
							if (addr_r == `WREM_ADDR_WIPER)
								tap_position_r <= shift_r[6:0];
							if (nv_we)
								wrote_nv_r <= 1'b1;
							// Pointer wraps in the page; host keeps within it.
							addr_r <= {addr_r[10:4], addr_r[3:0] + 4'h1};
						end
					end
					S_RDATA: addr_r <= addr_r + 11'h001;
					default: sda_oe_r <= 1'b0;
					endcase
				end else if (scl_fall && bit_r == B_ACK) begin
					bit_r <= 4'h0;
					sda_oe_r <= 1'b0;
					// Load the next byte and put its MSB out once the ack ends.
					if (state_r == S_RDATA && ack_r) begin
						shift_r <= rd_byte;
						sda_oe_r <= ~rd_byte[7];
					end
				end else if (scl_fall && state_r == S_RDATA && bit_r != 4'h0) begin
					sda_oe_r <= ~shift_r[3'h7 - bit_r[2:0]];
					sda_out_r <= 1'b0;
				end else if (scl_fall) begin
					sda_oe_r <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [logic/wrem_consts.vh]
// Constants for the wiper register and non-volatile memory map block.
// Assumes a 10 MHz system clock and an I2C slave front end inside the block.
`ifndef WREM_CONSTS_VH
`define WREM_CONSTS_VH
`define WREM_ADDR_W 11
`define WREM_TAP_W 7
`define WREM_MEM_BYTES 2048
`define WREM_PAGE_BYTES 16
`define WREM_PAGES 128
`define WREM_ADDR_GP_TOP 11'h7FB
`define WREM_ADDR_RSVD_A 11'h7FC
`define WREM_ADDR_RSVD_B 11'h7FD
`define WREM_ADDR_ACCESS 11'h7FE
`define WREM_ADDR_WIPER 11'h7FF
`define WREM_TAP_MID 7'h40
`define WREM_SEL_BIT 7
`define WREM_ID_PATTERN 4'hA
`define WREM_CLK_HZ 10000000
`define WREM_TWC_TYP_MS 6
`define WREM_TWC_MAX_MS 12
`define WREM_TWC_CYC ((`WREM_TWC_TYP_MS * `WREM_CLK_HZ) / 1000)
`define WREM_BOOT_CYC 8
`define WREM_NV_ERASED 8'hFF
`endif

// [logic/wrem_nv_array.v]
// Non-volatile byte array with a page buffer and a self-timed commit.
// Assumes the owner loads the page buffer and pulses commit after a stop.
`timescale 1ns/1ps
`default_nettype none
`include "wrem_consts.vh"
module wrem_nv_array #(
	parameter ADDR_W = `WREM_ADDR_W,
	parameter DEPTH = `WREM_MEM_BYTES,
	parameter PAGE = `WREM_PAGE_BYTES,
	parameter TWC_CYC = `WREM_TWC_CYC
) (
	input wire clk,
	input wire reset,
	input wire [ADDR_W-1:0] rd_addr,
	output wire [7:0] rd_data,
	input wire buf_we,
	input wire [ADDR_W-1:0] buf_addr,
	input wire [7:0] buf_data,
	input wire commit,
	output reg busy_r
);
	reg [7:0] mem [0:DEPTH-1];
	reg [7:0] pbuf [0:PAGE-1];
	reg [PAGE-1:0] pdirty_r;
	reg [ADDR_W-5:0] ppage_r;
	reg [31:0] cnt_r;
	integer i;

	// Cells start erased, so a fresh part boots to a known tap code.
	initial begin
		for (i = 0; i < DEPTH; i = i + 1)
			mem[i] = `WREM_NV_ERASED;
	end

	assign rd_data = mem[rd_addr];

	// The buffered bytes of the page land in one internal write cycle.
	always @(posedge clk) begin
		if (reset) begin
			busy_r <= 1'b0;
			cnt_r <= 32'h0;
			pdirty_r <= {PAGE{1'b0}};
			ppage_r <= {(ADDR_W-4){1'b0}};
		end else if (busy_r) begin
			if (cnt_r == 32'h0) begin
				busy_r <= 1'b0;
				for (i = 0; i < PAGE; i = i + 1) begin
					if (pdirty_r[i])
						mem[{ppage_r, i[3:0]}] <= pbuf[i];
				end
				pdirty_r <= {PAGE{1'b0}};
			end else begin
				cnt_r <= cnt_r - 32'h1;
			end
		end else if (commit && (pdirty_r != {PAGE{1'b0}})) begin
			busy_r <= 1'b1;
			cnt_r <= TWC_CYC - 1;
		end else if (buf_we) begin
			pbuf[buf_addr[3:0]] <= buf_data;
			pdirty_r[buf_addr[3:0]] <= 1'b1;
			ppage_r <= buf_addr[ADDR_W-1:4];
		end
	end
endmodule
`default_nettype wire

// [test/wrem_chk.sv]
// Port checker for the wiper register block.
// Assumes binding into wrem_top with the same commit length.
`timescale 1ns/1ps
`default_nettype none
module wrem_chk #(parameter TWC_CYC = 50) (
	input wire clk,
	input wire reset,
	input wire scl,
	input wire sda_in,
	input wire sda_out_r,
	input wire sda_oe_r,
	input wire write_protect_n,
	input wire [6:0] tap_position_r,
	input wire volatile_select_bit_r,
	input wire nv_busy_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// A counter, since the commit is far longer than a repetition.
	reg [31:0] bc_r;
	always @(posedge clk) bc_r <= nv_busy_r ? bc_r + 1 : 0;
	a_tap_mid: assert property ($fell(reset) |-> tap_position_r == 7'h40)
		else $error("tap not midscale");
	a_sel_clear: assert property ($fell(reset) |-> !volatile_select_bit_r)
		else $error("select not clear");
	a_idle_reset: assert property ($fell(reset) |-> !sda_oe_r && !nv_busy_r)
		else $error("not idle after reset");
	a_busy_quiet: assert property (nv_busy_r |-> !sda_oe_r)
		else $error("data driven in commit");
	a_busy_len: assert property ($fell(nv_busy_r) |-> bc_r == TWC_CYC)
		else $error("commit length wrong");
	a_busy_max: assert property (bc_r <= TWC_CYC)
		else $error("commit too long");
	a_sel_hold: assert property (nv_busy_r |-> $stable(volatile_select_bit_r))
		else $error("select moved in commit");
	a_tap_hold: assert property (nv_busy_r |-> $stable(tap_position_r))
		else $error("tap moved in commit");
	a_stop_start: assert property ($rose(nv_busy_r) |-> scl && sda_in)
		else $error("commit without stop");
	a_oe_low: assert property ($changed(sda_oe_r) |-> !scl)
		else $error("data moved with clock high");
	a_out_low: assert property (sda_out_r == 1'b0)
		else $error("data pin driven high");
	c_commit: cover property ($rose(nv_busy_r));
	c_sel: cover property ($rose(volatile_select_bit_r));
	c_reset: cover property ($fell(reset));
endmodule
bind wrem_top wrem_chk #(.TWC_CYC(TWC_CYC)) i_wrem_chk (.clk(clk),
	.reset(reset), .scl(scl), .sda_in(sda_in), .sda_out_r(sda_out_r),
	.sda_oe_r(sda_oe_r), .write_protect_n(write_protect_n),
	.tap_position_r(tap_position_r),
	.volatile_select_bit_r(volatile_select_bit_r), .nv_busy_r(nv_busy_r));
`default_nettype wire

// [test/wrem_host.sv]
// Two-wire bus master model: drives the clock, pulls data low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module wrem_host (
	input wire clk,
	input wire sda,
	output logic scl,
	output logic pull
);
	logic [7:0] q;
	logic k;
	initial begin
		scl = 1;
		pull = 0;
	end
	task automatic hp;
		repeat (4) @(posedge clk);
	endtask
	// Data moves only with the clock low and is read late in the high.
	task automatic bt(input b, output r);
		pull <= !b;
		hp;
		scl <= 1;
		hp;
		r = sda;
		scl <= 0;
	endtask
	task automatic xb(input [7:0] d, input a, output [7:0] o, output n);
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], k);
			o[i] = k;
		end
		bt(a, n);
	endtask
	task automatic st;
		pull <= 0;
		hp;
		scl <= 1;
		hp;
		pull <= 1;
		hp;
		scl <= 0;
	endtask
	task automatic sp;
		pull <= 1;
		hp;
		scl <= 1;
		hp;
		pull <= 0;
		hp;
	endtask
	task automatic wr(input [3:0] p, input [10:0] a, input [7:0] d0,
		input [7:0] d1, input two, output ok);
		logic n0, n1, n2, n3;
		st;
		xb({p, a[10:8], 1'b0}, 1, q, n0);
		xb(a[7:0], 1, q, n1);
		xb(d0, 1, q, n2);
		n3 = 0;
		if (two) xb(d1, 1, q, n3);
		sp;
		ok = !(n0 | n1 | n2 | n3);
	endtask
	task automatic rd(input [10:0] a, output [7:0] d);
		logic n;
		st;
		xb({4'hA, a[10:8], 1'b0}, 1, q, n);
		xb(a[7:0], 1, q, n);
		st;
		xb({4'hA, a[10:8], 1'b1}, 1, q, n);
		xb(8'hFF, 1, d, n);
		sp;
	endtask
endmodule
`default_nettype wire

// [test/wrem_top_tb.sv]
// Self-checking bench for the wiper block over the two-wire bus.
// Assumes a pull-up on the data wire and a short commit.
`timescale 1ns/1ps
`default_nettype none
module wrem_top_tb;
	localparam NV_WRITE_CYCLE_TIME = 50;
	logic clk = 0;
	logic reset = 1;
	logic wp_n = 1;
	wire scl, pull, sda, dout, doe, sel, busy;
	wire [6:0] tap;
	logic [7:0] d;
	logic ok;
	int bad_count = 0;
	int n_tests = 0;
	assign sda = !(pull | doe);
	always #50 clk = ~clk;
	wrem_top #(.TWC_CYC(NV_WRITE_CYCLE_TIME)) i_wrem_top (.clk(clk), .reset(reset),
		.scl(scl), .sda_in(sda), .sda_out_r(dout), .sda_oe_r(doe),
		.write_protect_n(wp_n), .tap_position_r(tap),
		.volatile_select_bit_r(sel), .nv_busy_r(busy));
	wrem_host i_wrem_host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
	task automatic chk(input [7:0] g, input [7:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wt;
		int i;
		repeat (2) @(posedge clk);
		for (i = 0; i < NV_WRITE_CYCLE_TIME + 20 && busy !== 0; i++) @(posedge clk);
		chk(busy, 0);
	endtask
	task automatic rst;
		reset <= 1;
		repeat (10) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		#1;
		chk(tap, 8'h40);
		chk(sel, 0);
		repeat (20) @(posedge clk);
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		final_report;
	end
	// Reserved bytes are never written by this bench.
	initial begin
		rst;
		i_wrem_host.wr(4'hA, 11'h123, 8'hA5, 0, 0, ok);
		wt;
		i_wrem_host.rd(11'h123, d);
		chk(d, 8'hA5);
		$display("test 1 done");
		i_wrem_host.wr(4'hA, 11'h7FF, 8'hD5, 0, 0, ok);
		chk(tap, 8'h55);
		wt;
		i_wrem_host.rd(11'h7FF, d);
		chk(d, 8'h55);
		$display("test 2 done");
		i_wrem_host.wr(4'hA, 11'h7FE, 8'h80, 8'h2A, 1, ok);
		chk(ok, 1);
		chk(sel, 1);
		chk(busy, 0);
		chk(tap, 8'h2A);
		i_wrem_host.rd(11'h7FF, d);
		chk(d, 8'h2A);
		i_wrem_host.rd(11'h7FE, d);
		chk(d, 8'h80);
		i_wrem_host.wr(4'hA, 11'h7FE, 8'h00, 0, 0, ok);
		chk(sel, 0);
		i_wrem_host.rd(11'h7FF, d);
		chk(d, 8'h55);
		$display("test 3 done");
		wp_n <= 0;
		i_wrem_host.wr(4'hA, 11'h7FF, 8'h11, 0, 0, ok);
		repeat (8) @(posedge clk);
		wp_n <= 1;
		chk(ok, 0);
		chk(tap, 8'h2A);
		i_wrem_host.wr(4'h5, 11'h7FF, 8'h33, 0, 0, ok);
		chk(ok, 0);
		chk(tap, 8'h2A);
		$display("test 4 done");
		rst;
		chk(tap, 8'h55);
		$display("test 5 done");
		final_report;
	end
endmodule
`default_nettype wire
